// ===== core/ssmc_supply_supervisor.sv
// The implementer's own choices: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`include "ssmc_params.svh"

// Functional notes
// R1 - full-perf re-enable masks events for 2 us
// R2 - supervisor event flag set tristates pins until settled
// R3 - event sets flag; por enable adds reset
// R4 - keep clear: off in deep sleep, back after
// R5 - manual, keep set: comparators stay on in sleep
// R6 - after clear/por enable both, no settle
// R7 - disabled before clear: flag setting off after
// R8 - any control write re-enables flag setting
// R9 - low side normal: 150 us wake mask
// R10 - low side off or full: 2 us mask
// R11 - sub-main clock from oscillator stays unmasked
// R12 - low normal mode: 150 us settling delay
// R13 - low full perf: 2 us settling delay
// R14 - delay flags set while settling after write
// R15 - manual, keep clear: normal goes off in sleep
// R16 - auto: off in sleep except kept full
module ssmc_supply_supervisor (
	input  wire logic        ref_clk,
	input  wire logic        rst,
	input  wire logic        porIn,
	input  wire logic        softClearIn,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        deepSleepIn,
	input  wire logic        lowSupTripIn,
	input  wire logic        highSupTripIn,
	input  wire logic        lowMonTripIn,
	input  wire logic        highMonTripIn,
	input  wire logic        subClkFromOscIn,
	output logic             irq,
	output logic             porReqOut,
	output logic             resetReqOut,
	output logic             pinsTristateOut,
	output logic             cpuHoldOut,
	output logic             subClkMaskOut,
	output logic             deepLowPowerOut
);
	localparam int CW = `SSMC_CNT_W;
	localparam logic [CW-1:0] FAST_LEN = CW'(`SSMC_FAST_CYC);
	localparam logic [CW-1:0] SLOW_LEN = CW'(`SSMC_SLOW_CYC);

	logic [`SSMC_CTL_W-1:0]  lowCtl_q;
	logic [`SSMC_CTL_W-1:0]  highCtl_q;
	logic [`SSMC_STAT_W-1:0] flags_q;
	logic [`SSMC_STAT_W-1:0] mask_q;
	logic                    flagEnable_q;
	logic [4:0]              trip1_q;
	logic [4:0]              trip2_q;
	logic                    sleep_q;
	logic                    sleepPrev_q;
	logic                    lowFpPrev_q;
	logic                    highFpPrev_q;
	logic                    lowModeFullPrev_q;
	logic                    highModeFullPrev_q;
	logic                    ack_q;
	ssmc_pkg::ssmc_wake_t    wake_q;

	ssmc_pkg::ssmc_mode_t    lowSupMode;
	ssmc_pkg::ssmc_mode_t    highSupMode;
	ssmc_pkg::ssmc_mode_t    lowMonMode;
	ssmc_pkg::ssmc_mode_t    highMonMode;

	logic ctlWrite;
	logic lowWrite;
	logic highWrite;
	logic flagWrite;
	logic maskWrite;
	logic lowSettle;
	logic highSettle;
	logic wakeBusy;
	logic lowMaskBusy;
	logic highMaskBusy;
	logic lowMaskStart;
	logic highMaskStart;
	logic wakeEdge;
	logic [CW-1:0] lowSettleLen;
	logic [CW-1:0] wakeLen;
	logic lowSupEv;
	logic highSupEv;
	logic lowMonEv;
	logic highMonEv;
	logic [`SSMC_STAT_W-1:0] evSet;
	logic porFire;

	function automatic logic isFull(input ssmc_pkg::ssmc_mode_t m);
		return m == ssmc_pkg::SSMC_FULL;
	endfunction

	function automatic logic isOn(input ssmc_pkg::ssmc_mode_t m);
		return m != ssmc_pkg::SSMC_OFF;
	endfunction

	// bus decode; one wait cycle, answer on the second
	assign ctlWrite  = avs_write && ack_q;
	assign lowWrite  = ctlWrite && avs_address == `SSMC_ADDR_LOWCTL;
	assign highWrite = ctlWrite && avs_address == `SSMC_ADDR_HIGHCTL;
	assign flagWrite = ctlWrite && avs_address == `SSMC_ADDR_FLAGS;
	assign maskWrite = ctlWrite && avs_address == `SSMC_ADDR_MASK;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= (avs_read || avs_write) && !ack_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && !ack_q);
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			avs_readdata <= 32'h0000_0000;
		end else if (avs_read && !ack_q) begin
			case (avs_address)
				`SSMC_ADDR_LOWCTL:  avs_readdata <= 32'(lowCtl_q);
				`SSMC_ADDR_HIGHCTL: avs_readdata <= 32'(highCtl_q);
				`SSMC_ADDR_FLAGS:   avs_readdata <= 32'(flags_q);
				`SSMC_ADDR_MASK:    avs_readdata <= 32'(mask_q);
				`SSMC_ADDR_STATE:   avs_readdata <= {24'h00_0000, lowSupMode, highSupMode,
				                                     lowMonMode, highMonMode};
				default:            avs_readdata <= 32'h0000_0000;
			endcase
		end
	end

	// control registers; a clear or por turns both supervisors on
	always_ff @(posedge ref_clk) begin
		if (rst || porIn || softClearIn) begin
			lowCtl_q <= `SSMC_CTL_RESET | (`SSMC_CTL_W'(1) << `SSMC_F_SUP_EN); // R6
		end else if (lowWrite) begin
			lowCtl_q <= avs_writedata[`SSMC_CTL_W-1:0];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst || porIn || softClearIn) begin
			highCtl_q <= `SSMC_CTL_RESET | (`SSMC_CTL_W'(1) << `SSMC_F_SUP_EN); // R6
		end else if (highWrite) begin
			highCtl_q <= avs_writedata[`SSMC_CTL_W-1:0];
		end
	end

	// flag setting lost over a clear if a supervisor was off
	always_ff @(posedge ref_clk) begin
		if (rst || porIn) begin
			flagEnable_q <= 1'b1;
		end else if (softClearIn) begin
			flagEnable_q <= lowCtl_q[`SSMC_F_SUP_EN] && highCtl_q[`SSMC_F_SUP_EN]; // R7
		end else if (lowWrite || highWrite) begin
			flagEnable_q <= 1'b1; // R8
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			mask_q <= '0;
		end else if (maskWrite) begin
			mask_q <= avs_writedata[`SSMC_STAT_W-1:0];
		end
	end

	// pin synchronisers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			trip1_q <= '0;
			trip2_q <= '0;
		end else begin
			trip1_q <= {deepSleepIn, highMonTripIn, lowMonTripIn, highSupTripIn, lowSupTripIn};
			trip2_q <= trip1_q;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sleep_q     <= 1'b0;
			sleepPrev_q <= 1'b0;
		end else begin
			sleep_q     <= trip2_q[4];
			sleepPrev_q <= sleep_q;
		end
	end

	ssmc_mode_sel u_lowSup (
		.enable      (lowCtl_q[`SSMC_F_SUP_EN]),
		.fullPerf    (lowCtl_q[`SSMC_F_SUP_FP]),
		.keepInSleep (lowCtl_q[`SSMC_F_SUP_KEEP]),
		.autoCtl     (lowCtl_q[`SSMC_F_AUTO]),
		.deepSleep   (sleep_q),
		.mode        (lowSupMode)
	);

	ssmc_mode_sel u_highSup (
		.enable      (highCtl_q[`SSMC_F_SUP_EN]),
		.fullPerf    (highCtl_q[`SSMC_F_SUP_FP]),
		.keepInSleep (highCtl_q[`SSMC_F_SUP_KEEP]),
		.autoCtl     (highCtl_q[`SSMC_F_AUTO]),
		.deepSleep   (sleep_q),
		.mode        (highSupMode)
	);

	// monitors have no keep bit: in sleep they stay on unless auto with full perf clear
	ssmc_mode_sel u_lowMon (
		.enable      (lowCtl_q[`SSMC_F_MON_EN]),
		.fullPerf    (lowCtl_q[`SSMC_F_MON_FP]),
		.keepInSleep (1'b1),
		.autoCtl     (lowCtl_q[`SSMC_F_AUTO]),
		.deepSleep   (sleep_q),
		.mode        (lowMonMode)
	);

	ssmc_mode_sel u_highMon (
		.enable      (highCtl_q[`SSMC_F_MON_EN]),
		.fullPerf    (highCtl_q[`SSMC_F_MON_FP]),
		.keepInSleep (1'b1),
		.autoCtl     (highCtl_q[`SSMC_F_AUTO]),
		.deepSleep   (sleep_q),
		.mode        (highMonMode)
	);

	// settling: 150 us normal, 2 us full, high side by its mode before the write; started by control writes only
	// a high-side write must not pick the low length from the high data
	assign lowSettleLen = (lowWrite ? avs_writedata[`SSMC_F_SUP_FP] : lowCtl_q[`SSMC_F_SUP_FP])
	                      ? FAST_LEN : SLOW_LEN; // R12 R13

	ssmc_delay #(.CNT_W(CW)) u_lowSettle (
		.clk   (ref_clk),
		.rst   (rst),
		.start (lowWrite || highWrite), // R14
		.len   (lowSettleLen),
		.busy  (lowSettle)
	);

	ssmc_delay #(.CNT_W(CW)) u_highSettle (
		.clk   (ref_clk),
		.rst   (rst),
		.start (lowWrite || highWrite), // R14
		.len   (highCtl_q[`SSMC_F_SUP_FP] ? FAST_LEN : SLOW_LEN),
		.busy  (highSettle)
	);

	// supervisor entering full-perf mode (from off or normal): 2 us event mask
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			lowModeFullPrev_q  <= 1'b0;
			highModeFullPrev_q <= 1'b0;
			lowFpPrev_q        <= 1'b0;
			highFpPrev_q       <= 1'b0;
		end else begin
			lowModeFullPrev_q  <= isOn(lowSupMode);
			highModeFullPrev_q <= isOn(highSupMode);
			lowFpPrev_q        <= isFull(lowSupMode);
			highFpPrev_q       <= isFull(highSupMode);
		end
	end

	assign lowMaskStart  = isFull(lowSupMode) && !(lowModeFullPrev_q && lowFpPrev_q); // R1
	assign highMaskStart = isFull(highSupMode) && !(highModeFullPrev_q && highFpPrev_q); // R1

	ssmc_delay #(.CNT_W(CW)) u_lowMask (
		.clk   (ref_clk),
		.rst   (rst),
		.start (lowMaskStart),
		.len   (FAST_LEN),
		.busy  (lowMaskBusy)
	);

	ssmc_delay #(.CNT_W(CW)) u_highMask (
		.clk   (ref_clk),
		.rst   (rst),
		.start (highMaskStart),
		.len   (FAST_LEN),
		.busy  (highMaskBusy)
	);

	// wake mask: slow only when low side runs in normal mode
	assign wakeEdge = sleepPrev_q && !sleep_q;
	assign wakeLen  = (lowCtl_q[`SSMC_F_SUP_EN] && !lowCtl_q[`SSMC_F_SUP_FP]) ||
	                  (lowCtl_q[`SSMC_F_MON_EN] && !lowCtl_q[`SSMC_F_MON_FP])
	                  ? SLOW_LEN : FAST_LEN; // R9 R10

	ssmc_delay #(.CNT_W(CW)) u_wake (
		.clk   (ref_clk),
		.rst   (rst),
		.start (wakeEdge),
		.len   (wakeLen),
		.busy  (wakeBusy)
	);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wake_q <= ssmc_pkg::SSMC_WAKE_IDLE;
		end else begin
			case (wake_q)
				ssmc_pkg::SSMC_WAKE_IDLE: if (wakeEdge) wake_q <= ssmc_pkg::SSMC_WAKE_HOLD;
				ssmc_pkg::SSMC_WAKE_HOLD: if (!wakeBusy) wake_q <= ssmc_pkg::SSMC_WAKE_IDLE;
				default:                  wake_q <= ssmc_pkg::SSMC_WAKE_IDLE;
			endcase
		end
	end

	// events: trip while comparator on and not settling; supervisor trips also not masked
	assign lowSupEv  = trip2_q[0] && isOn(lowSupMode) && !lowMaskBusy && !lowSettle;
	assign highSupEv = trip2_q[1] && isOn(highSupMode) && !highMaskBusy && !highSettle;
	assign lowMonEv  = trip2_q[2] && isOn(lowMonMode) && !lowSettle;
	assign highMonEv = trip2_q[3] && isOn(highMonMode) && !highSettle;

	assign evSet = {2'b00, highMonEv, lowMonEv, highSupEv, lowSupEv} &
	               {`SSMC_STAT_W{flagEnable_q}};

	// sticky event flags, live delay flags; set beats a write-one clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flags_q <= '0;
		end else begin
			flags_q[3:0] <= (flags_q[3:0] & ~({4{flagWrite}} & avs_writedata[3:0]))
			                | evSet[3:0]; // R3
			flags_q[`SSMC_S_LOW_DLY]  <= lowSettle; // R14
			flags_q[`SSMC_S_HIGH_DLY] <= highSettle; // R14
		end
	end

	assign porFire = (lowSupEv && lowCtl_q[`SSMC_F_SUP_POR]) ||
	                 (highSupEv && highCtl_q[`SSMC_F_SUP_POR]); // R3

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			porReqOut   <= 1'b0;
			resetReqOut <= 1'b0;
		end else begin
			porReqOut   <= porFire; // R3
			resetReqOut <= porFire;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pinsTristateOut <= 1'b0;
		end else begin
			pinsTristateOut <= (flags_q[`SSMC_S_LOW_SUP] || flags_q[`SSMC_S_HIGH_SUP]) &&
			                   (lowMaskBusy || highMaskBusy || lowSettle || highSettle); // R2
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cpuHoldOut      <= 1'b0;
			subClkMaskOut   <= 1'b0;
			deepLowPowerOut <= 1'b0;
			irq             <= 1'b0;
		end else begin
			cpuHoldOut      <= wakeEdge || wake_q == ssmc_pkg::SSMC_WAKE_HOLD; // R9
			// oscillator-sourced sub-main clock passes unmasked on wake
			subClkMaskOut   <= wake_q == ssmc_pkg::SSMC_WAKE_HOLD && !subClkFromOscIn; // R11
			deepLowPowerOut <= sleep_q;
			irq             <= |(flags_q & mask_q);
		end
	end
endmodule

// ===== core/ssmc_params.svh
`ifndef SSMC_PARAMS_SVH
`define SSMC_PARAMS_SVH

// register word indices on the bus address
`define SSMC_ADDR_LOWCTL   4'h0
`define SSMC_ADDR_HIGHCTL  4'h1
`define SSMC_ADDR_FLAGS    4'h2
`define SSMC_ADDR_MASK     4'h3
`define SSMC_ADDR_STATE    4'h4

// control field positions, same layout for low and high control
`define SSMC_F_SUP_EN      0
`define SSMC_F_SUP_KEEP    1
`define SSMC_F_SUP_FP      2
`define SSMC_F_SUP_POR     3
`define SSMC_F_MON_EN      4
`define SSMC_F_MON_FP      5
`define SSMC_F_AUTO        6
`define SSMC_CTL_W         7
`define SSMC_CTL_RESET     7'h00

// status flag positions
`define SSMC_S_LOW_SUP     0
`define SSMC_S_HIGH_SUP    1
`define SSMC_S_LOW_MON     2
`define SSMC_S_HIGH_MON    3
`define SSMC_S_LOW_DLY     4
`define SSMC_S_HIGH_DLY    5
`define SSMC_STAT_W        6

// timing
`define SSMC_CLK_MHZ       100
`define SSMC_MASK_US       2
`define SSMC_SLOW_US       150
`define SSMC_FAST_CYC      (`SSMC_MASK_US * `SSMC_CLK_MHZ)
`define SSMC_SLOW_CYC      (`SSMC_SLOW_US * `SSMC_CLK_MHZ)
`define SSMC_CNT_W         16

`endif

// ===== core/ssmc_pkg.sv
package ssmc_pkg;
	typedef enum logic [1:0] {
		SSMC_OFF,
		SSMC_NORMAL,
		SSMC_FULL
	} ssmc_mode_t;

	typedef enum logic [1:0] {
		SSMC_WAKE_IDLE,
		SSMC_WAKE_HOLD
	} ssmc_wake_t;
endpackage

// ===== core/ssmc_delay.sv
`timescale 1ns/1ps
`include "ssmc_params.svh"

module ssmc_delay #(
	parameter int CNT_W = `SSMC_CNT_W
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic             start,
	input  wire logic [CNT_W-1:0] len,
	output logic                  busy
);
	logic [CNT_W-1:0] count_q;

	// restart on every start, a retrigger reloads the window from len
	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= '0;
		end else if (start) begin
			count_q <= len;
		end else if (count_q != '0) begin
			count_q <= count_q - 1'b1;
		end
	end

	assign busy = (count_q != '0);
endmodule

// ===== core/ssmc_mode_sel.sv
`timescale 1ns/1ps
`include "ssmc_params.svh"

module ssmc_mode_sel (
	input  wire logic             enable,
	input  wire logic             fullPerf,
	input  wire logic             keepInSleep,
	input  wire logic             autoCtl,
	input  wire logic             deepSleep,
	output ssmc_pkg::ssmc_mode_t  mode
);
	always_comb begin
		if (!enable) begin
			mode = ssmc_pkg::SSMC_OFF;
		end else if (!deepSleep) begin
			mode = fullPerf ? ssmc_pkg::SSMC_FULL : ssmc_pkg::SSMC_NORMAL;
		end else if (!keepInSleep) begin
			mode = ssmc_pkg::SSMC_OFF; // R4 R15
		end else if (autoCtl) begin
			mode = fullPerf ? ssmc_pkg::SSMC_NORMAL : ssmc_pkg::SSMC_OFF; // R16
		end else begin
			mode = fullPerf ? ssmc_pkg::SSMC_FULL : ssmc_pkg::SSMC_NORMAL; // R5
		end
	end
endmodule

// ===== bench/ssmc_properties.sv
`timescale 1ns/1ps
`include "ssmc_params.svh"

module ssmc_properties (
	input wire logic        ref_clk,
	input wire logic        rst,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic        deepSleepIn,
	input wire logic        subClkFromOscIn,
	input wire logic        irq,
	input wire logic        porReqOut,
	input wire logic        resetReqOut,
	input wire logic        cpuHoldOut,
	input wire logic        subClkMaskOut,
	input wire logic        deepLowPowerOut
);
	// slack covers wakes stacked by quick re-entry
	logic [15:0] holdCnt_q;
	always_ff @(posedge ref_clk) begin
		if (rst || !cpuHoldOut) begin
			holdCnt_q <= 16'h0000;
		end else begin
			holdCnt_q <= holdCnt_q + 16'h0001;
		end
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("request not answered");
	a_answer_single: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("answer held too long");
	a_no_spurious: assert property (!avs_read && !avs_write |=> avs_waitrequest)
		else $error("answer without request");
	a_data_on_read: assert property ($changed(avs_readdata) |-> !avs_waitrequest && avs_read)
		else $error("read data moved outside a read");
	a_sleep_enter: assert property (deepSleepIn [*5] |-> deepLowPowerOut)
		else $error("sleep not seen");
	a_sleep_leave: assert property (!deepSleepIn [*5] |-> !deepLowPowerOut)
		else $error("wake not seen");
	a_por_resets: assert property (porReqOut |-> resetReqOut)
		else $error("por without reset");
	a_osc_unmasked: assert property (subClkFromOscIn && $past(subClkFromOscIn) |-> !subClkMaskOut)
		else $error("oscillator clock masked");
	a_hold_bounded: assert property (holdCnt_q <= `SSMC_SLOW_CYC + 1000)
		else $error("wake hold too long");
	c_por: cover property (porReqOut);
	c_wake: cover property ($fell(cpuHoldOut));
	c_irq: cover property (irq);
endmodule

bind ssmc_supply_supervisor ssmc_properties ssmc_properties_i (.*);

// ===== bench/ssmc_supply_supervisor_tb_top.sv
`timescale 1ns/1ps
`include "ssmc_params.svh"

module ssmc_supply_supervisor_tb_top;
	logic        ref_clk;
	logic        rst;
	logic        porIn;
	logic        softClearIn;
	logic [3:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        deepSleepIn;
	logic [3:0]  trips;
	wire logic   lowSupTripIn;
	wire logic   highSupTripIn;
	wire logic   lowMonTripIn;
	wire logic   highMonTripIn;
	logic        subClkFromOscIn;
	logic        irq;
	logic        porReqOut;
	logic        resetReqOut;
	logic        pinsTristateOut;
	logic        cpuHoldOut;
	logic        subClkMaskOut;
	logic        deepLowPowerOut;
	int          cyc;
	int          n_mismatch;
	int          num_checks;
	// low control, low modes awake, low modes asleep
	localparam logic [7:0] MC [8] = '{8'h00, 8'h01, 8'h03, 8'h07, 8'h47, 8'h43, 8'h13, 8'h73};
	localparam logic [7:0] MA [8] = '{8'h00, 8'h40, 8'h40, 8'h80, 8'h80, 8'h40, 8'h44, 8'h48};
	localparam logic [7:0] MS [8] = '{8'h00, 8'h00, 8'h40, 8'h80, 8'h40, 8'h00, 8'h44, 8'h04};

	assign {highMonTripIn, lowMonTripIn, highSupTripIn, lowSupTripIn} = trips;

	ssmc_supply_supervisor ssmc_supply_supervisor_i (.*);

	always #5 ref_clk = !ref_clk;
	always @(posedge ref_clk) cyc <= cyc + 1;

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic tmo();
		n_mismatch++;
		$display("unexpected at %0t wait limit %0h exp %0h", $time, 0, 1);
		wrap_up();
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected at %0t got %0h exp %0h", $time, g, e);
		end
	endtask

	// delay counts, slack for bus polling
	task automatic near(input int g, input int e);
		num_checks++;
		if (g < e - 8 || g > e + 8) begin
			n_mismatch++;
			$display("unexpected at %0t count %0h exp %0h", $time, g, e);
		end
	endtask

	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int i;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (i == 20) tmo();
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rc(input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask

	task automatic poll(input int b, output int t);
		int i;
		logic [31:0] q;
		t = cyc;
		for (i = 0; i < 9000; i++) begin
			bus(1'b0, 4'h2, 32'h0, q);
			if (q[b] === 1'b0) break;
		end
		if (i == 9000) tmo();
		t = cyc - t;
	endtask

	task automatic doze(input logic v);
		int i;
		deepSleepIn <= v;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (deepLowPowerOut === v) break;
		end
		if (i == 20) tmo();
		@(posedge ref_clk);
	endtask

	task automatic wake(input int w, output int t, output int m);
		int i;
		t = 0;
		m = 0;
		deepSleepIn <= 1'b0;
		for (i = 0; i < w; i++) begin
			@(posedge ref_clk);
			t += (cpuHoldOut === 1'b1);
			m += (subClkMaskOut === 1'b1);
		end
	endtask

	// pulse long enough for the trip synchronisers
	task automatic trip(input logic [3:0] v, output logic p);
		int i;
		p = 1'b0;
		trips <= v;
		for (i = 0; i < 16; i++) begin
			@(posedge ref_clk);
			p |= (porReqOut === 1'b1 && resetReqOut === 1'b1);
			if (i == 7) trips <= 4'h0;
		end
	endtask

	task automatic t_reset();
		rc(4'h0, '1, 32'h01);
		rc(4'h1, '1, 32'h01);
		rc(4'h2, '1, 32'h00);
		rc(4'h5, '1, 32'h00);
		wr(4'h4, 32'hFF);
		rc(4'h4, '1, 32'h50);
		chk({31'h0, irq}, 32'h0);
		$display("t_reset done");
	endtask

	task automatic t_settle();
		int t;
		wr(4'h0, 32'h01);
		rc(4'h2, 32'h30, 32'h30);
		poll(4, t);
		near(t, `SSMC_SLOW_CYC);
		wr(4'h0, 32'h05);
		poll(4, t);
		near(t, `SSMC_FAST_CYC);
		rc(4'h2, 32'h20, 32'h20);
		$display("t_settle done");
	endtask

	task automatic t_wake();
		int t;
		int m;
		subClkFromOscIn <= 1'b1;
		wr(4'h0, 32'h01);
		doze(1'b1);
		wake(`SSMC_SLOW_CYC + 50, t, m);
		near(t, `SSMC_SLOW_CYC);
		chk(m, 32'h0);
		subClkFromOscIn <= 1'b0;
		wr(4'h0, 32'h35);
		doze(1'b1);
		wake(300, t, m);
		near(t, `SSMC_FAST_CYC);
		near(m, `SSMC_FAST_CYC);
		wr(4'h0, 32'h00);
		doze(1'b1);
		wake(300, t, m);
		near(t, `SSMC_FAST_CYC);
		$display("t_wake done");
	endtask

	task automatic t_mode();
		int i;
		for (i = 0; i < 8; i++) begin
			wr(4'h0, {24'h0, MC[i]});
			rc(4'h4, 32'hCC, {24'h0, MA[i]});
			doze(1'b1);
			rc(4'h4, 32'hCC, {24'h0, MS[i]});
			doze(1'b0);
			rc(4'h4, 32'hCC, {24'h0, MA[i]});
		end
		$display("t_mode done");
	endtask

	task automatic t_clr();
		int t;
		logic p;
		wr(4'h0, 32'h04);
		poll(4, t);
		softClearIn <= 1'b1;
		@(posedge ref_clk);
		softClearIn <= 1'b0;
		@(posedge ref_clk);
		rc(4'h0, '1, 32'h01);
		trip(4'h1, p);
		rc(4'h2, 32'h1F, 32'h00);
		wr(4'h0, 32'h0D);
		poll(4, t);
		trip(4'h1, p);
		chk({31'h0, p}, 32'h1);
		rc(4'h2, 32'h0F, 32'h01);
		chk({31'h0, pinsTristateOut}, 32'h1);
		wr(4'h2, 32'h0F);
		wr(4'h1, 32'h00);
		chk({31'h0, pinsTristateOut}, 32'h0);
		porIn <= 1'b1;
		@(posedge ref_clk);
		porIn <= 1'b0;
		@(posedge ref_clk);
		rc(4'h1, '1, 32'h01);
		$display("t_clr done");
	endtask

	task automatic t_evt();
		int t;
		logic p;
		wr(4'h3, 32'h01);
		wr(4'h0, 32'h1D);
		trip(4'h1, p);
		rc(4'h2, 32'h0F, 32'h00);
		poll(4, t);
		trip(4'h1, p);
		chk({31'h0, p}, 32'h1);
		trip(4'h4, p);
		rc(4'h2, 32'h0F, 32'h05);
		chk({31'h0, irq}, 32'h1);
		wr(4'h2, 32'h01);
		rc(4'h2, 32'h0F, 32'h04);
		chk({31'h0, irq}, 32'h0);
		wr(4'h2, 32'h04);
		rc(4'h2, 32'h0F, 32'h00);
		// full-perf comparator back on after sleep, no low-side settle running
		doze(1'b1);
		doze(1'b0);
		trip(4'h1, p);
		chk({31'h0, p}, 32'h0);
		rc(4'h2, 32'h0F, 32'h00);
		$display("t_evt done");
	endtask

	initial begin
		ref_clk = 1'b0;
		rst = 1'b1;
		porIn = 1'b0;
		softClearIn = 1'b0;
		avs_address = 4'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		deepSleepIn = 1'b0;
		trips = 4'h0;
		subClkFromOscIn = 1'b0;
		cyc = 0;
		n_mismatch = 0;
		num_checks = 0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_settle();
		t_wake();
		t_mode();
		t_clr();
		t_evt();
		wrap_up();
	end
endmodule
